// [include/tbs_pkg.sv]
// test bus selector package: register map, select codes, carriers
// assumes a 125 MHz pclk and an 8-bit APB address space
package tbs_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // delays from delimiter detect to header flags, in ns
  localparam int SIG_READY_NS = 8000;
  localparam int LEN_READY_NS = 32000;
  localparam int CRC_READY_NS = 48000;
  localparam int SIG_READY_CYC = SIG_READY_NS / CLK_PERIOD_NS;
  localparam int LEN_READY_CYC = LEN_READY_NS / CLK_PERIOD_NS;
  localparam int CRC_READY_CYC = CRC_READY_NS / CLK_PERIOD_NS;
  // register byte addresses
  localparam logic [7:0] ADDR_RX_LEN_LOW = 8'h6C;
  localparam logic [7:0] ADDR_TEST_SEL = 8'h70;
  localparam logic [7:0] ADDR_TEST_MON = 8'h74;
  localparam logic [7:0] TEST_SEL_RESET = 8'h00;
  // select codes
  localparam logic [7:0] SEL_QUIET = 8'h00;
  localparam logic [7:0] SEL_RX_ACQ = 8'h01;
  localparam logic [7:0] SEL_TX_FIELD = 8'h02;
  localparam logic [7:0] SEL_RSSI = 8'h03;
  localparam logic [7:0] SEL_QM1 = 8'h04;
  localparam logic [7:0] SEL_QM2_LO = 8'h05;
  localparam logic [7:0] SEL_CORR_LO = 8'h06;
  localparam logic [7:0] SEL_FREQ_LO = 8'h07;
  localparam logic [7:0] SEL_PHASE_LO = 8'h08;
  localparam logic [7:0] SEL_NCO_LO = 8'h09;
  localparam logic [7:0] SEL_BITSYNC = 8'h0A;
  localparam logic [7:0] SEL_PN = 8'h0B;
  localparam logic [7:0] SEL_CAL = 8'h0C;
  localparam logic [7:0] SEL_CORR_I = 8'h0D;
  localparam logic [7:0] SEL_CORR_Q = 8'h0E;
  localparam logic [7:0] SEL_CHIP_ERR = 8'h0F;
  localparam logic [7:0] SEL_NCO_HI = 8'h10;
  localparam logic [7:0] SEL_LAG_HI = 8'h11;
  localparam logic [7:0] SEL_PHASE_ERR = 8'h12;
  localparam logic [7:0] SEL_INPHASE_ROTATION_ERROR = 8'h13;
  localparam logic [7:0] SEL_QUADRATURE_ROTATION_ERROR = 8'h14;
  localparam logic [7:0] SEL_ADC = 8'h15;
  localparam logic [7:0] SEL_XOR_HI = 8'h16;
  localparam logic [7:0] SEL_XOR_LO = 8'h17;
  localparam logic [7:0] SEL_TIMING = 8'h18;
  localparam logic [7:0] SEL_CAL_ACC_LO = 8'h19;
  localparam logic [7:0] SEL_CAL_ACC_HI = 8'h1A;
  localparam logic [7:0] SEL_FREQ_ACC = 8'h1B;
  localparam logic [7:0] SEL_XOR_SLOW = 8'h1C;
  localparam logic [7:0] SEL_QM2_HI = 8'h1D;
  localparam logic [7:0] SEL_RSVD_A = 8'h1E;
  localparam logic [7:0] SEL_RSVD_B = 8'h1F;
  // modem state sampled on pclk
  typedef struct packed {
    logic cal_full_scale;
    logic carrier_sense_flag;
    logic energy_detect_flag;
    logic track_start;
    logic sfd_detect;
    logic header_crc_ok;
    logic initial_detect;
    logic transmit_enable_input;
    logic preamble_start;
    logic delim_start;
    logic sig_start;
    logic len_start;
    logic crc_start;
    logic payload_start;
    logic symbol_boundary_marker;
    logic enh_early_carrier_sense;
    logic early_carrier_sense;
    logic [5:0] rssi;
    logic [7:0] quality_metric_one;
    logic [15:0] quality_metric_two;
    logic [15:0] quality_metric_three;
    logic quality_metric_three_div;
    logic quality_valid;
    logic [7:0] corr_mag_lo;
    logic [18:0] freq_lo;
    logic [7:0] phase_lo;
    logic [15:0] nco_lo;
    logic [4:0] bitsync_acc;
    logic [2:0] bitsync_exp;
    logic last_symbol;
    logic [8:0] pn_top;
    logic cal_disable;
    logic [4:0] cal_value;
    logic [8:0] corr_i_hi;
    logic [8:0] corr_q_hi;
    logic [14:0] chip_err_acc;
    logic [19:0] nco_hi;
    logic [18:0] lag_hi;
    logic [6:0] phase_err;
    logic [5:0] inphase_rotation_error;
    logic [5:0] quadrature_rotation_error;
    logic [2:0] i_adc;
    logic [2:0] q_adc;
    logic [8:0] xor_hi;
    logic [8:0] xor_lo;
    logic [7:0] xor_slow;
    logic jump_clk;
    logic timing_jump_count;
    logic [4:0] master_timing_count;
    logic [17:0] cal_acc;
    logic [15:0] freq_acc;
    logic [7:0] rx_length_low;
  } tbs_modem_t;
  // modem clocks arriving from outside the pclk domain
  typedef struct packed {
    logic cal_clk;
    logic rssi_adc_clk;
    logic symbol_rate_clock;
    logic sample_clk;
  } tbs_clk_t;
endpackage : tbs_pkg

// [rtl/tbs_test_bus.sv]
// test bus selector: routes a chosen modem signal group to 8 pins + strobe
// assumes modem state on pclk, modem clocks asynchronous, APB master
//
// Contract
// - select zero drives outputs and strobe low
// - acquisition flags rise in turn, clear after frame
// - acquisition bit order; strobe shows initial detect
// - signal, length, crc flags at 8/32/48 us
// - transmit field flags rise in turn, then clear
// - transmit bit order; strobe marks symbol boundary
// - early sense flags plus six-bit strength
// - quality values on 04h, 05h, 1Dh
// - 06h correlator magnitude, sample clock strobe
// - 07h-09h frequency, phase, NCO slices
// - 0Ah bit sync accumulator and exponent
// - 0Bh nine pseudo-noise bits incl. strobe
// - 0Ch calibration flags and value
// - 0Dh/0Eh high-rate I/Q correlator bits
// - 0Fh chip error bits, strobe low
// - 10h NCO and 11h lag accumulators
// - 12h-14h phase and rotation errors sign-extended
// - 15h zeros plus I and Q samples
// - 16h/17h/1Ch XOR fault data
// - 18h timing signals, sample clock strobe
// - 19h-1Bh accumulator nine-bit slices
// - read-only received length low byte
// - reserved selects drive everything low
// - monitor register reads the test outputs
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
module tbs_test_bus #(
  parameter int SIG_CYC = tbs_pkg::SIG_READY_CYC, // signal field delay
  parameter int LEN_CYC = tbs_pkg::LEN_READY_CYC, // length field delay
  parameter int CRC_CYC = tbs_pkg::CRC_READY_CYC  // header crc delay
) (
  input wire logic pclk, // 125 MHz bus and modem clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire tbs_pkg::tbs_modem_t mdm, // modem state
  input wire tbs_pkg::tbs_clk_t mclk, // raw modem clocks
  output logic [7:0] test_out, // test pins 7:0
  output logic test_strobe // test strobe pin
);
  import tbs_pkg::*;

  localparam int TW = $clog2(CRC_CYC + 1);

  // refuse delay sets the timer cannot order, at elaboration
  if (!(SIG_CYC > 0 && SIG_CYC < LEN_CYC && LEN_CYC < CRC_CYC))
  begin : g_bad_delays
    $error("tbs_test_bus: delays must be increasing and nonzero");
  end

  logic [7:0] test_sel;
  logic [7:0] next_out;
  logic next_strobe;
  logic [3:0] clk_s1;
  logic [3:0] clk_s2;
  tbs_clk_t ck;
  logic [TW-1:0] frame_cyc;
  logic sig_ready;
  logic len_ready;
  logic crc_ready;
  logic setup;
  logic access;
  logic mapped;

  // two-flop synchronisers; only the second stage is ever read
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          clk_s1[g] <= 1'b0;
          clk_s2[g] <= 1'b0;
        end
        else
        begin
          clk_s1[g] <= mclk[g];
          clk_s2[g] <= clk_s1[g];
        end
      end
    end
  endgenerate
  assign ck = tbs_clk_t'(clk_s2);

  // cycles since delimiter detect; held at zero outside a frame so the
  // header flags drop together with the acquisition flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_cyc <= '0;
    else if (!mdm.sfd_detect)
      frame_cyc <= '0;
    else if (frame_cyc != TW'(CRC_CYC))
      frame_cyc <= frame_cyc + TW'(1);
  end

  // header flags; crc also needs the modem's crc verdict
  assign sig_ready = mdm.sfd_detect && frame_cyc >= TW'(SIG_CYC);
  assign len_ready = mdm.sfd_detect && frame_cyc >= TW'(LEN_CYC);
  assign crc_ready = mdm.sfd_detect && frame_cyc >= TW'(CRC_CYC)
                     && mdm.header_crc_ok;

  // routing mux; unknown selects fall to a quiet bus
  always_comb
  begin
    next_out = 8'h00;
    next_strobe = 1'b0;
    unique case (test_sel)
      SEL_QUIET: ;
      SEL_RX_ACQ:
      begin
        next_out = {mdm.cal_full_scale, mdm.carrier_sense_flag,
                    mdm.energy_detect_flag, mdm.track_start,
                    mdm.sfd_detect, sig_ready, len_ready,
                    crc_ready};
        next_strobe = mdm.initial_detect;
      end
      SEL_TX_FIELD:
      begin
        next_out = {mdm.cal_full_scale, mdm.transmit_enable_input,
                    mdm.preamble_start, mdm.delim_start, mdm.sig_start,
                    mdm.len_start, mdm.crc_start,
                    mdm.payload_start};
        next_strobe = mdm.symbol_boundary_marker;
      end
      SEL_RSSI:
      begin
        next_out = {mdm.enh_early_carrier_sense, mdm.early_carrier_sense,
                    mdm.rssi};
        next_strobe = ck.rssi_adc_clk;
      end
      SEL_QM1:
      begin
        next_out = mdm.quality_metric_one;
        next_strobe = mdm.quality_valid;
      end
      SEL_QM2_LO:
      begin
        next_out = mdm.quality_metric_three_div ?
                   mdm.quality_metric_three[7:0] :
                   mdm.quality_metric_two[7:0];
        next_strobe = mdm.quality_valid;
      end
      SEL_QM2_HI:
      begin
        next_out = mdm.quality_metric_three_div ?
                   mdm.quality_metric_three[15:8] :
                   mdm.quality_metric_two[15:8];
        next_strobe = mdm.quality_valid;
      end
      SEL_CORR_LO:
      begin
        next_out = mdm.corr_mag_lo;
        next_strobe = ck.sample_clk;
      end
      SEL_FREQ_LO:
      begin
        next_out = mdm.freq_lo[18:11];
        next_strobe = ck.symbol_rate_clock;
      end
      SEL_PHASE_LO:
      begin
        next_out = mdm.phase_lo;
        next_strobe = ck.symbol_rate_clock;
      end
      SEL_NCO_LO:
      begin
        next_out = mdm.nco_lo[15:8];
        next_strobe = ck.symbol_rate_clock;
      end
      SEL_BITSYNC:
      begin
        next_out = {mdm.bitsync_acc, mdm.bitsync_exp};
        next_strobe = mdm.last_symbol;
      end
      SEL_PN: {next_out, next_strobe} = mdm.pn_top;
      SEL_CAL:
      begin
        next_out = {mdm.cal_full_scale, mdm.energy_detect_flag,
                    mdm.cal_disable, mdm.cal_value};
        next_strobe = ck.cal_clk;
      end
      SEL_CORR_I:
      begin
        next_out = mdm.corr_i_hi[8:1];
        next_strobe = ck.sample_clk;
      end
      SEL_CORR_Q:
      begin
        next_out = mdm.corr_q_hi[8:1];
        next_strobe = ck.sample_clk;
      end
      SEL_CHIP_ERR: next_out = mdm.chip_err_acc[14:7];
      SEL_NCO_HI:
      begin
        next_out = mdm.nco_hi[19:12];
        next_strobe = ck.sample_clk;
      end
      SEL_LAG_HI:
      begin
        next_out = mdm.lag_hi[18:11];
        next_strobe = ck.sample_clk;
      end
      SEL_PHASE_ERR:
      begin
        next_out = {mdm.phase_err[6], mdm.phase_err};
        next_strobe = ck.sample_clk;
      end
      SEL_INPHASE_ROTATION_ERROR:
      begin
        next_out = {{2{mdm.inphase_rotation_error[5]}},
                    mdm.inphase_rotation_error};
        next_strobe = ck.sample_clk;
      end
      SEL_QUADRATURE_ROTATION_ERROR:
      begin
        next_out = {{2{mdm.quadrature_rotation_error[5]}},
                    mdm.quadrature_rotation_error};
        next_strobe = ck.sample_clk;
      end
      SEL_ADC:
      begin
        next_out = {2'h0, mdm.i_adc, mdm.q_adc};
        next_strobe = ck.sample_clk;
      end
      SEL_XOR_HI: {next_out, next_strobe} = mdm.xor_hi;
      SEL_XOR_LO: {next_out, next_strobe} = mdm.xor_lo;
      SEL_XOR_SLOW:
      begin
        next_out = mdm.xor_slow;
        next_strobe = ck.symbol_rate_clock;
      end
      SEL_TIMING:
      begin
        next_out = {mdm.jump_clk, mdm.timing_jump_count,
                    ck.symbol_rate_clock,
                    mdm.master_timing_count};
        next_strobe = ck.sample_clk;
      end
      SEL_CAL_ACC_LO: {next_out, next_strobe} = mdm.cal_acc[8:0];
      SEL_CAL_ACC_HI: {next_out, next_strobe} = mdm.cal_acc[17:9];
      SEL_FREQ_ACC: {next_out, next_strobe} = mdm.freq_acc[15:7];
      default: ;
    endcase
  end

  // registered pins keep glitches off the test header
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      test_out <= 8'h00;
      test_strobe <= 1'b0;
    end
    else
    begin
      test_out <= next_out;
      test_strobe <= next_strobe;
    end
  end

  // apb: no wait states, answer prepared during the setup cycle
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign mapped = paddr == ADDR_RX_LEN_LOW || paddr == ADDR_TEST_SEL
                  || paddr == ADDR_TEST_MON;

  // select register; only byte lane 0 carries it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      test_sel <= TEST_SEL_RESET;
    else if (access && pwrite && paddr == ADDR_TEST_SEL && pstrb[0])
      test_sel <= pwdata[7:0];
  end

  // ready rises for exactly the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  // read data and error; writes to read-only words are refused
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= !mapped || (pwrite && paddr != ADDR_TEST_SEL);
      prdata <= 32'h0000_0000;
      if (!pwrite)
      begin
        unique case (paddr)
          ADDR_RX_LEN_LOW: prdata[7:0] <= mdm.rx_length_low;
          ADDR_TEST_SEL: prdata[7:0] <= test_sel;
          ADDR_TEST_MON: prdata[7:0] <= test_out;
          default: ;
        endcase
      end
    end
    else
    begin
      pslverr <= 1'b0;
    end
  end

  // checks
  AST_QUIET_BUS: assert property (@(posedge pclk) disable iff (!presetn)
    test_sel == SEL_QUIET |=> test_out == 8'h00 && !test_strobe)
    else $error("quiet select left the test bus active");
  AST_RESERVED_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    (test_sel == SEL_RSVD_A || test_sel == SEL_RSVD_B)
    |=> test_out == 8'h00 && !test_strobe)
    else $error("reserved select drove the test bus");
  AST_SIG_READY_TIME: assert property (@(posedge pclk)
    disable iff (!presetn)
    $rose(sig_ready) |-> frame_cyc == TW'(SIG_CYC))
    else $error("signal field flag rose at the wrong time");
  AST_FLAGS_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    test_sel == SEL_RX_ACQ && !mdm.sfd_detect
    |=> test_out[2:0] == 3'h0)
    else $error("header flags stayed up after the frame");
  AST_RSSI_MAP: assert property (@(posedge pclk) disable iff (!presetn)
    test_sel == SEL_RSSI |=> test_out[5:0] == $past(mdm.rssi))
    else $error("strength sample misrouted");
  AST_QM_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    test_sel == SEL_QM2_HI && !mdm.quality_metric_three_div
    |=> test_out == $past(mdm.quality_metric_two[15:8]))
    else $error("quality high byte misrouted");
  AST_ADC_TOP_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    test_sel == SEL_ADC |=> test_out[7:6] == 2'h0)
    else $error("converter select left top bits set");
  AST_CHIP_STROBE: assert property (@(posedge pclk) disable iff (!presetn)
    test_sel == SEL_CHIP_ERR |=> !test_strobe)
    else $error("chip error select raised the strobe");
  AST_MON_READ: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && paddr == ADDR_TEST_MON
    |-> prdata[7:0] == $past(test_out))
    else $error("monitor read does not match the test pins");
  AST_SEL_LATENCY: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == ADDR_TEST_SEL && pstrb[0]
    |=> test_sel == $past(pwdata[7:0]))
    else $error("select write did not take effect");
  COV_RX_CRC: cover property (@(posedge pclk) disable iff (!presetn)
    test_sel == SEL_RX_ACQ && crc_ready);
  COV_SEL_WRITE: cover property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == ADDR_TEST_SEL);
  COV_BAD_ADDR: cover property (@(posedge pclk) disable iff (!presetn)
    access && pslverr);
endmodule : tbs_test_bus

// [test/tbs_probe.sv]
// pin probe: stands in for the logic analyser on the test pins
// assumes pins are sampled on pclk, strobe edges found by the probe
`timescale 1ns/10ps
module tbs_probe (
  input wire logic pclk, // sampling clock
  input wire logic [7:0] test_out, // test pins
  input wire logic test_strobe, // strobe pin
  output int strobe_rises, // strobe rising edges seen
  output logic [7:0] last_word // pins latched at each strobe rise
);
  logic strobe_q = 1'b0;
  int rise_cnt = 0;
  assign strobe_rises = rise_cnt;
  // an analyser latches the pins on the strobe edge, like a real capture
  always @(posedge pclk)
  begin
    strobe_q <= test_strobe;
    if (test_strobe === 1'b1 && strobe_q === 1'b0)
    begin
      rise_cnt <= rise_cnt + 1;
      last_word <= test_out;
    end
  end
endmodule : tbs_probe

// [test/testbench.sv]
// self-checking bench for the test bus selector
// assumes short header delays via parameters and a free modem sample clock
`timescale 1ns/10ps
module testbench;
  import tbs_pkg::*;
  localparam int SIG = 4;
  localparam int LEN = 8;
  localparam int CRC = 12;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  tbs_modem_t mdm = '0;
  tbs_clk_t mclk = '0;
  logic [7:0] test_out;
  logic test_strobe;
  int failures = 0;
  int tests_run = 0;
  int seed = 32'hc765;
  int sclk_rises = 0;
  int probe_rises;
  logic [7:0] probe_word;

  always #4 pclk = ~pclk;
  // modem clocks, phase unrelated to pclk; 160 ns sample clock
  initial
  begin
    #3;
    forever
    begin
      #80;
      mclk.sample_clk = ~mclk.sample_clk;
      if (mclk.sample_clk)
      begin
        sclk_rises++;
        if (sclk_rises % 4 == 0)
          mclk.symbol_rate_clock = ~mclk.symbol_rate_clock;
        mclk.rssi_adc_clk = $random(seed);
        mclk.cal_clk = $random(seed);
      end
    end
  end

  tbs_test_bus #(.SIG_CYC(SIG), .LEN_CYC(LEN), .CRC_CYC(CRC)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mdm(mdm),
    .mclk(mclk), .test_out(test_out), .test_strobe(test_strobe));
  tbs_probe PROBE (.pclk(pclk), .test_out(test_out),
    .test_strobe(test_strobe), .strobe_rises(probe_rises),
    .last_word(probe_word));

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] st, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    // a slave that never answers ends the run through the verdict
    if (n == 50)
    begin
      failures++;
      report_and_stop();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // expected pins: [9] strobe is predictable and checked, [8:1] pins, [0] strobe
  function automatic logic [9:0] exp_pins(input logic [7:0] s,
                                          input tbs_modem_t m);
    logic [15:0] q;
    q = m.quality_metric_three_div ? m.quality_metric_three
                                   : m.quality_metric_two;
    case (s)
      8'h00: return 10'h200;
      8'h01: return {1'b1, m.cal_full_scale, m.carrier_sense_flag,
                     m.energy_detect_flag, m.track_start, m.sfd_detect,
                     3'b000, m.initial_detect};
      8'h02: return {1'b1, m.cal_full_scale, m.transmit_enable_input,
                     m.preamble_start, m.delim_start, m.sig_start,
                     m.len_start, m.crc_start, m.payload_start,
                     m.symbol_boundary_marker};
      8'h03: return {1'b0, m.enh_early_carrier_sense,
                     m.early_carrier_sense, m.rssi, 1'b0};
      8'h04: return {1'b1, m.quality_metric_one, m.quality_valid};
      8'h05: return {1'b1, q[7:0], m.quality_valid};
      8'h06: return {1'b0, m.corr_mag_lo, 1'b0};
      8'h07: return {1'b0, m.freq_lo[18:11], 1'b0};
      8'h08: return {1'b0, m.phase_lo, 1'b0};
      8'h09: return {1'b0, m.nco_lo[15:8], 1'b0};
      8'h0A: return {1'b1, m.bitsync_acc, m.bitsync_exp, m.last_symbol};
      8'h0B: return {1'b1, m.pn_top};
      8'h0C: return {1'b0, m.cal_full_scale, m.energy_detect_flag,
                     m.cal_disable, m.cal_value, 1'b0};
      8'h0D: return {1'b0, m.corr_i_hi[8:1], 1'b0};
      8'h0E: return {1'b0, m.corr_q_hi[8:1], 1'b0};
      8'h0F: return {1'b1, m.chip_err_acc[14:7], 1'b0};
      8'h10: return {1'b0, m.nco_hi[19:12], 1'b0};
      8'h11: return {1'b0, m.lag_hi[18:11], 1'b0};
      8'h12: return {1'b0, m.phase_err[6], m.phase_err, 1'b0};
      8'h13: return {1'b0, {2{m.inphase_rotation_error[5]}},
                     m.inphase_rotation_error, 1'b0};
      8'h14: return {1'b0, {2{m.quadrature_rotation_error[5]}},
                     m.quadrature_rotation_error, 1'b0};
      8'h15: return {1'b0, 2'b00, m.i_adc, m.q_adc, 1'b0};
      8'h16: return {1'b1, m.xor_hi};
      8'h17: return {1'b1, m.xor_lo};
      8'h18: return {1'b0, m.jump_clk, m.timing_jump_count, 1'b0,
                     m.master_timing_count, 1'b0};
      8'h19: return {1'b1, m.cal_acc[8:0]};
      8'h1A: return {1'b1, m.cal_acc[17:9]};
      8'h1B: return {1'b1, m.freq_acc[15:7]};
      8'h1C: return {1'b0, m.xor_slow, 1'b0};
      8'h1D: return {1'b1, q[15:8], m.quality_valid};
      default: return 10'h200;
    endcase
  endfunction : exp_pins

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #400000;
    failures++;
    report_and_stop();
  end

  initial
  begin
    logic [31:0] rd;
    logic err;
    logic [7:0] sel;
    logic [7:0] mask;
    logic [9:0] e;
    tbs_modem_t m;
    int rs;
    int rl;
    int rc;
    int p0;
    int s0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk("reset_pins", 9'h000, {test_out, test_strobe});
    apb(1'b0, ADDR_TEST_SEL, 32'h0, 4'hF, rd, err);
    chk("reset_sel", {24'h0, TEST_SEL_RESET}, rd);
    // sweep every select plus two outside the table with random sources
    for (int s = 0; s < 34; s++)
    begin
      sel = (s == 33) ? 8'hA5 : 8'(s);
      for (int b = 0; b < $bits(m); b++) m[b] = $random(seed);
      m.sfd_detect = 1'b0;
      @(posedge pclk);
      mdm <= m;
      apb(1'b1, ADDR_TEST_SEL, {24'h0, sel}, 4'hF, rd, err);
      chk("sel_write_err", 0, err);
      repeat (2) @(posedge pclk);
      #1;
      e = exp_pins(sel, m);
      mask = (sel == SEL_TIMING) ? 8'hDF : 8'hFF;
      chk("test_out", e[8:1] & mask, test_out & mask);
      if (e[9]) chk("strobe", e[0], test_strobe);
      apb(1'b0, ADDR_TEST_MON, 32'h0, 4'hF, rd, err);
      chk("monitor", {24'h0, e[8:1] & mask}, rd & {24'h0, mask});
      apb(1'b0, ADDR_TEST_SEL, 32'h0, 4'hF, rd, err);
      chk("sel_readback", {24'h0, sel}, rd);
    end
    // header flags after the delimiter: spacing fixed by the delays
    apb(1'b1, ADDR_TEST_SEL, {24'h0, SEL_RX_ACQ}, 4'hF, rd, err);
    m.header_crc_ok = 1'b1;
    m.sfd_detect = 1'b1;
    @(posedge pclk);
    mdm <= m;
    rs = -1;
    rl = -1;
    rc = -1;
    for (int n = 1; n < CRC + 8; n++)
    begin
      @(posedge pclk);
      #1;
      if (rs < 0 && test_out[2] === 1'b1) rs = n;
      if (rl < 0 && test_out[1] === 1'b1) rl = n;
      if (rc < 0 && test_out[0] === 1'b1) rc = n;
    end
    chk("sig_window", 1, rs >= SIG && rs <= SIG + 3);
    chk("len_after_sig", LEN - SIG, rl - rs);
    chk("crc_after_sig", CRC - SIG, rc - rs);
    @(posedge pclk);
    mdm.sfd_detect <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk("flags_clear", 3'b000, test_out[2:0]);
    // status byte is read-only; unmapped words refuse
    apb(1'b0, ADDR_RX_LEN_LOW, 32'h0, 4'hF, rd, err);
    chk("rx_len_low", {24'h0, m.rx_length_low}, rd);
    apb(1'b1, ADDR_RX_LEN_LOW, ~rd, 4'hF, rd, err);
    chk("rx_len_wr_err", 1, err);
    apb(1'b0, ADDR_RX_LEN_LOW, 32'h0, 4'hF, rd, err);
    chk("rx_len_kept", {24'h0, m.rx_length_low}, rd);
    apb(1'b0, 8'h40, 32'h0, 4'hF, rd, err);
    chk("unmapped_err", 1, err);
    chk("unmapped_rd", 0, rd);
    apb(1'b1, ADDR_TEST_SEL, {24'h0, SEL_CORR_LO}, 4'hE, rd, err);
    apb(1'b0, ADDR_TEST_SEL, 32'h0, 4'hF, rd, err);
    chk("strobe_masked_wr", {24'h0, SEL_RX_ACQ}, rd);
    // correlator select: strobe follows the sample clock
    apb(1'b1, ADDR_TEST_SEL, {24'h0, SEL_CORR_LO}, 4'hF, rd, err);
    repeat (4) @(posedge pclk);
    p0 = probe_rises;
    s0 = sclk_rises;
    repeat (200) @(posedge pclk);
    p0 = probe_rises - p0;
    s0 = sclk_rises - s0;
    chk("strobe_rate", 1, p0 >= s0 - 1 && p0 <= s0 + 1);
    chk("probe_word", {24'h0, m.corr_mag_lo}, {24'h0, probe_word});
    report_and_stop();
  end
endmodule : testbench
